// File: src/dram_refresh_access_controller.sv
// Dynamic RAM controller: arbitration, address multiplexing, strobes.
// Assumes strap levels are seen as plain logic inputs, synchronous to clk_i.
//
// What this block does
// R1: Row address comes from the low-order address inputs.
// R2: Raised size strap selects 4K RAM mode, normal level selects 16K.
// R3: Column address comes from the high-order address inputs.
// R4: In 4K mode top column bit is chip select; in 16K it is column MSB.
// R5: Multiplexed address drives RAM; in 4K mode top line is chip select.
// R6: Write strobe drives the RAM write enables.
// R7: Column strobe latches the column address into RAM.
// R8: Bank select picks one of four banks; only its row strobe asserts.
// R9: Advanced read strap swaps request pin roles and disables banks 0 and 1.
// R10: Normal mode: low read request asks for a read cycle.
// R11: Advanced mode: status latched at latch-enable falling edge; high means read.
// R12: Low store request asks for a write cycle.
// R13: Read and write requests count only while guarded select is low.
// R14: Guarded select going high never cuts short a running cycle.
// R15: Normal mode: high refresh request asks for a refresh cycle.
// R16: Advanced mode offers no transparent refresh.
// R17: Transfer done pulses marking read data valid or write data taken.
// R18: Access begin asserts at start of access as early acknowledge.
// R19: Access request during refresh delays access begin to transfer done.
// R20: Clock strap high selects external clock instead of crystal.
// R21: All operations are timed from the single clock.
// R22: Arbiter chooses among read, write and refresh cycles.
// R23: Idle controller samples requests on the rising clock edge.
// R24: Simultaneous access and refresh: access runs first.
// R25: Refresh row counter supplies refresh address; increments after each refresh.
// R26: Refresh timer restarts whenever a refresh cycle starts from idle.
// R27: Refresh interval is a parameter in clock cycles.
module dram_refresh_access_controller
	import dram_ctrl_pkg::*;
#(
	parameter int unsigned REFRESH_INTERVAL = REF_INTERVAL
) (
	input  wire logic       clk_i,
	input  wire logic       arst_n_i,
	input  wire logic [5:0] row_address_in_i,
	input  wire logic       row_msb_or_ram_size_strap_i,
	input  wire logic       ram_size_strap_i,
	input  wire logic [6:0] column_address_in_i,
	input  wire logic       bank_select_lsb_i,
	input  wire logic       bank_msb_or_advanced_read_strap_i,
	input  wire logic       advanced_read_strap_i,
	input  wire logic       read_request_n_i,
	input  wire logic       store_request_n_i,
	input  wire logic       guarded_select_n_i,
	input  wire logic       refresh_request_i,
	input  wire logic       crystal_or_clock_strap_i,
	output logic      [6:0] muxed_address_bus_o,
	output logic      [3:0] row_strobe_n_o,
	output logic            column_strobe_n_o,
	output logic            write_strobe_n_o,
	output logic            transfer_done_n_o,
	output logic            access_begin_n_o,
	output logic            external_clock_sel_o
);
	import dram_ctrl_pkg::*;

	// Bank decode used for the access row strobe path only; refresh uses fixed patterns
	function automatic logic [3:0] bank_decode(input logic [1:0] sel);
		bank_decode = ~(4'h1 << sel);
	endfunction

	refresh_if rif ();

	refresh_timer #(
		.INTERVAL (REFRESH_INTERVAL)
	) u_timer (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.rif      (rif)
	);

	ctrl_state_e state_ff;
	op_kind_e    op_ff;
	logic [2:0]  phase_ff;
	logic [6:0]  ref_row_ff;
	logic        ref_pend_ff;
	logic        delay_ack_ff;
	logic        ale_prev_ff;
	logic        adv_read_ff;
	logic [5:0]  row_lat_ff;
	logic        row_msb_lat_ff;
	logic [6:0]  col_lat_ff;
	logic [1:0]  bank_lat_ff;
	logic [6:0]  mux_ff;
	logic [3:0]  ras_ff;
	logic        cas_ff;
	logic        we_ff;
	logic        transfer_done_n_ff;
	logic        access_begin_n_ff;
	logic        ext_clk_ff;

	logic        mode_4k;
	logic        adv_mode;
	logic        rd_req;
	logic        wr_req;
	logic        ref_req;
	logic        ale_fall;
	logic [1:0]  bank_sel;
	logic        phase_end;

	assign mode_4k  = ram_size_strap_i; // R2
	assign adv_mode = advanced_read_strap_i; // R9
	assign ale_fall = adv_mode && ale_prev_ff && !refresh_request_i;
	// Gated requests; select only qualifies new requests
	assign rd_req   = !guarded_select_n_i && (adv_mode ? adv_read_ff : !read_request_n_i); // R10 R11 R13
	assign wr_req   = !guarded_select_n_i && !store_request_n_i; // R12 R13
	assign ref_req  = ref_pend_ff || rif.due || (!adv_mode && refresh_request_i); // R15 R16
	// In advanced mode the upper bank pin is a strap, banks 2 and 3 only
	assign bank_sel = adv_mode ? {1'b1, bank_select_lsb_i}
	                           : {bank_msb_or_advanced_read_strap_i, bank_select_lsb_i}; // R8 R9
	assign phase_end = (phase_ff == 3'h0);
	assign rif.restart = (state_ff == ST_IDLE) && ref_req && !(rd_req || wr_req); // R26

	assign muxed_address_bus_o  = mux_ff;
	assign row_strobe_n_o       = ras_ff;
	assign column_strobe_n_o    = cas_ff;
	assign write_strobe_n_o     = we_ff;
	assign transfer_done_n_o    = transfer_done_n_ff;
	assign access_begin_n_o     = access_begin_n_ff;
	assign external_clock_sel_o = ext_clk_ff;

	// Clock source select reported for the clock tree
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ext_clk_ff <= 1'b0;
		end else begin
			ext_clk_ff <= crystal_or_clock_strap_i; // R20 R21
		end
	end

	// Latch enable history for edge detect
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ale_prev_ff <= 1'b0;
		end else begin
			ale_prev_ff <= refresh_request_i;
		end
	end

	// Status latch on falling latch enable
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			adv_read_ff <= 1'b0;
		end else if (ale_fall) begin
			adv_read_ff <= read_request_n_i; // R11
		end else if (state_ff == ST_IDLE && adv_read_ff && rd_req && !wr_req) begin
			adv_read_ff <= 1'b0;
		end
	end

	// Pending refresh: request during access runs after it
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ref_pend_ff <= 1'b0;
		// Pin request taken at once is not kept
		end else if (!adv_mode && refresh_request_i && !rif.restart) begin
			ref_pend_ff <= 1'b1; // R24
		end else if (rif.due && state_ff != ST_IDLE) begin
			ref_pend_ff <= 1'b1;
		end else if (rif.restart) begin
			ref_pend_ff <= 1'b0;
		end
	end

	// Delayed acknowledge when access asked during refresh
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			delay_ack_ff <= 1'b0;
		end else if ((state_ff == ST_REF || (state_ff == ST_PRE && op_ff == OP_REFRESH))
		             && (rd_req || wr_req)) begin
			delay_ack_ff <= 1'b1; // R19
		end else if (state_ff == ST_PRE && op_ff != OP_REFRESH) begin
			delay_ack_ff <= 1'b0;
		end
	end

	// Refresh row counter
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ref_row_ff <= REF_ROW_RST;
		end else if (state_ff == ST_REF && phase_end) begin
			ref_row_ff <= ref_row_ff + 7'h01; // R25
		end
	end

	// Operation kind chosen at cycle start
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			op_ff <= OP_READ;
		end else if (state_ff == ST_IDLE) begin
			if (wr_req) begin
				op_ff <= OP_WRITE; // R22
			end else if (rd_req) begin
				op_ff <= OP_READ;
			end else if (ref_req) begin
				op_ff <= OP_REFRESH;
			end
		end
	end

	// Cycle sequencer; once started a cycle runs to its end
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_ff <= ST_IDLE;
			phase_ff <= 3'h0;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					if (wr_req) begin // R22 R23 R24
						state_ff <= ST_ROW;
						phase_ff <= 3'(ROW_CYCLES - 1);
					end else if (rd_req) begin
						state_ff <= ST_ROW;
						phase_ff <= 3'(ROW_CYCLES - 1);
					end else if (ref_req) begin
						state_ff <= ST_REF;
						phase_ff <= 3'(REFRESH_CYCLES - 1);
					end
				end
				ST_ROW: begin // R14
					if (phase_end) begin
						state_ff <= ST_COL;
						phase_ff <= 3'(COL_CYCLES - 1);
					end else begin
						phase_ff <= phase_ff - 3'h1;
					end
				end
				ST_COL: begin
					if (phase_end) begin
						state_ff <= ST_ACK;
					end else begin
						phase_ff <= phase_ff - 3'h1;
					end
				end
				ST_ACK: begin
					state_ff <= ST_PRE;
					phase_ff <= 3'(PRECHARGE_CYC - 1);
				end
				ST_REF: begin
					if (phase_end) begin
						state_ff <= ST_PRE;
						phase_ff <= 3'(PRECHARGE_CYC - 1);
					end else begin
						phase_ff <= phase_ff - 3'h1;
					end
				end
				ST_PRE: begin
					if (phase_end) begin
						state_ff <= ST_IDLE;
					end else begin
						phase_ff <= phase_ff - 3'h1;
					end
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	// Address and bank capture at cycle start
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			row_lat_ff     <= 6'h00;
			row_msb_lat_ff <= 1'b0;
			col_lat_ff     <= 7'h00;
			bank_lat_ff    <= 2'h0;
		end else if (state_ff == ST_IDLE) begin
			row_lat_ff     <= row_address_in_i; // R1
			row_msb_lat_ff <= row_msb_or_ram_size_strap_i;
			col_lat_ff     <= column_address_in_i; // R3
			bank_lat_ff    <= bank_sel;
		end
	end

	// Address multiplexer
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mux_ff <= MUX_IDLE;
		end else begin
			case (state_ff)
				ST_ROW: begin
					// 4K: top line carries chip select through the cycle
					mux_ff <= mode_4k ? {col_lat_ff[TOP_BIT], row_lat_ff}
					                  : {row_msb_lat_ff, row_lat_ff}; // R1 R4 R5
				end
				ST_COL, ST_ACK: begin
					mux_ff <= col_lat_ff; // R3 R4 R5
				end
				ST_REF: begin
					mux_ff <= mode_4k ? {1'b0, ref_row_ff[5:0]} : ref_row_ff; // R25
				end
				default: begin
					mux_ff <= MUX_IDLE;
				end
			endcase
		end
	end

	// Row strobes: one bank for access, all enabled banks for refresh
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ras_ff <= STROBES_IDLE;
		end else if ((state_ff == ST_ROW && phase_ff != 3'(ROW_CYCLES - 1))
		             || state_ff == ST_COL || state_ff == ST_ACK) begin
			ras_ff <= bank_decode(bank_lat_ff); // R8
		end else if (state_ff == ST_REF) begin
			ras_ff <= adv_mode ? 4'h3 : 4'h0; // R9
		end else begin
			ras_ff <= STROBES_IDLE;
		end
	end

	// Column strobe
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cas_ff <= 1'b1;
		end else begin
			cas_ff <= !((state_ff == ST_COL && phase_ff != 3'(COL_CYCLES - 1)) || state_ff == ST_ACK); // R7
		end
	end

	// Write strobe
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			we_ff <= 1'b1;
		end else begin
			we_ff <= !((state_ff == ST_COL || state_ff == ST_ACK) && op_ff == OP_WRITE); // R6
		end
	end

	// Transfer done pulse
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			transfer_done_n_ff <= 1'b1;
		end else begin
			transfer_done_n_ff <= !(state_ff == ST_ACK); // R17
		end
	end

	// Access begin, early or delayed
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			access_begin_n_ff <= 1'b1;
		end else if (state_ff == ST_ROW && phase_ff == 3'(ROW_CYCLES - 1) && !delay_ack_ff) begin
			access_begin_n_ff <= 1'b0; // R18
		end else if (state_ff == ST_ACK) begin
			access_begin_n_ff <= 1'b0; // R19
		end else if (state_ff == ST_PRE || state_ff == ST_IDLE) begin
			access_begin_n_ff <= 1'b1; // R14
		end
	end
endmodule

// File: pkg/dram_ctrl_pkg.sv
// Shared constants and types for the dynamic RAM controller.
// Assumes a single 20 MHz clock and no register bus.
package dram_ctrl_pkg;
	localparam int unsigned CLK_PERIOD_NS  = 50;
	localparam int unsigned ROW_CYCLES     = 2;
	localparam int unsigned COL_CYCLES     = 3;
	localparam int unsigned PRECHARGE_CYC  = 2;
	localparam int unsigned REFRESH_CYCLES = 4;
	localparam int unsigned REF_INTERVAL   = 300;
	localparam logic [6:0]  REF_ROW_RST    = 7'h00;
	localparam logic [6:0]  MUX_IDLE       = 7'h7F;
	localparam logic [3:0]  STROBES_IDLE   = 4'hF;
	localparam int unsigned TOP_BIT        = 6;

	typedef enum logic [6:0] {
		ST_IDLE   = 7'b0000001,
		ST_ROW    = 7'b0000010,
		ST_COL    = 7'b0000100,
		ST_ACK    = 7'b0001000,
		ST_REF    = 7'b0010000,
		ST_PRE    = 7'b0100000,
		ST_UNUSED = 7'b1000000
	} ctrl_state_e;

	typedef enum logic [1:0] {
		OP_READ    = 2'h0,
		OP_WRITE   = 2'h1,
		OP_REFRESH = 2'h2
	} op_kind_e;
endpackage

// File: pkg/refresh_if.sv
// Carrier between the controller and its refresh timer.
// Assumes both ends share one clock.
interface refresh_if;
	logic restart;
	logic due;
	modport ctrl  (output restart, input due);
	modport timer (input restart, output due);
endinterface

// File: src/refresh_timer.sv
// Internal refresh interval timer.
// Assumes restart is a one-cycle pulse from the controller.
module refresh_timer
	import dram_ctrl_pkg::*;
#(
	parameter int unsigned INTERVAL = REF_INTERVAL
) (
	input  wire logic clk_i,
	input  wire logic arst_n_i,
	refresh_if.timer  rif
);
	localparam int unsigned CW = $clog2(INTERVAL + 1);
	logic [CW-1:0] count_ff;
	logic          due_ff;

	assign rif.due = due_ff;

	// Count toward the next refresh
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			count_ff <= '0;
		end else if (rif.restart) begin
			count_ff <= '0; // R26
		end else if (count_ff != CW'(INTERVAL - 1)) begin
			count_ff <= count_ff + CW'(1);
		end
	end

	// Sticky due flag, set wins over restart
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			due_ff <= 1'b0;
		end else if (count_ff == CW'(INTERVAL - 2)) begin
			due_ff <= 1'b1; // R27
		end else if (rif.restart) begin
			due_ff <= 1'b0;
		end
	end
endmodule

// File: testbench/dram_ctrl_sva.sv
// Port checker for the dynamic RAM controller.
// Bound to every controller instance, one clock domain.
module dram_ctrl_sva
	import dram_ctrl_pkg::*;
#(
	parameter int unsigned REFRESH_INTERVAL = REF_INTERVAL
) (
	input wire logic	clk_i,
	input wire logic	arst_n_i,
	input wire logic	advanced_read_strap_i,
	input wire logic	crystal_or_clock_strap_i,
	input wire logic [6:0]	muxed_address_bus_o,
	input wire logic [3:0]	row_strobe_n_o,
	input wire logic	column_strobe_n_o,
	input wire logic	write_strobe_n_o,
	input wire logic	transfer_done_n_o,
	input wire logic	access_begin_n_o,
	input wire logic	external_clock_sel_o
);
	localparam int unsigned QUIET_MAX = REFRESH_INTERVAL + 12;
	logic [6:0]	ref_cnt_ff;
	logic [9:0]	quiet_ff;
	logic	ref_q_ff;
	wire logic	ref_on = (row_strobe_n_o == 4'h0) || (row_strobe_n_o == 4'h3);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	// Expected refresh row
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ref_cnt_ff <= REF_ROW_RST;
			ref_q_ff <= 1'b0;
		end else begin
			ref_q_ff <= ref_on;
			if (ref_q_ff && !ref_on)
				ref_cnt_ff <= ref_cnt_ff + 7'h01;
		end
	end
	// Cycles with no row strobe
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			quiet_ff <= 10'h000;
		else if (row_strobe_n_o != STROBES_IDLE)
			quiet_ff <= 10'h000;
		else
			quiet_ff <= quiet_ff + 10'h001;
	end
	AST_TRANSFER_DONE_N_ONE: assert property ($fell(transfer_done_n_o) |=> transfer_done_n_o)
		else $error("transfer done longer than one cycle");
	AST_ACCESS_BEGIN_N_LEAD: assert property ($fell(access_begin_n_o) && transfer_done_n_o |-> ##5 $fell(transfer_done_n_o))
		else $error("access begin not five cycles before transfer done");
	AST_ACCESS_BEGIN_N_DELAY: assert property ($fell(transfer_done_n_o) |-> !access_begin_n_o)
		else $error("access begin high at transfer done");
	AST_CAS_ROW: assert property (!column_strobe_n_o |-> $countones(~row_strobe_n_o) == 1)
		else $error("column strobe without exactly one row strobe");
	AST_ADV_BANKS: assert property (advanced_read_strap_i && $past(advanced_read_strap_i, 12) |-> &row_strobe_n_o[1:0])
		else $error("bank 0 or 1 strobed in advanced mode");
	AST_WE_CAS: assert property ($fell(write_strobe_n_o) |-> ##[0:2] !column_strobe_n_o)
		else $error("write strobe without column strobe");
	AST_REF_ROW: assert property (ref_on && column_strobe_n_o |-> muxed_address_bus_o == ref_cnt_ff)
		else $error("refresh address not the row counter");
	AST_REF_LEN: assert property ($rose(ref_on) |-> ref_on [*4] ##1 !ref_on)
		else $error("refresh strobe not four cycles");
	AST_TIMER: assert property (quiet_ff <= QUIET_MAX)
		else $error("internal refresh overdue");
	AST_CLK_SEL: assert property ($past(arst_n_i) |-> external_clock_sel_o == $past(crystal_or_clock_strap_i))
		else $error("clock select not following strap");
	cover property ($fell(transfer_done_n_o) && !write_strobe_n_o);
	cover property ($rose(ref_on));
	cover property ($fell(transfer_done_n_o) && $fell(access_begin_n_o));
endmodule
bind dram_refresh_access_controller dram_ctrl_sva #(.REFRESH_INTERVAL(REFRESH_INTERVAL)) dram_ctrl_sva_inst (.*);

// File: testbench/dram_array_model.sv
// RAM array stand-in: keeps what the strobes latch.
// Assumes strobes and address move just after rising edges.
module dram_array_model (
	input wire logic	clk_i,
	input wire logic [3:0]	row_strobe_n_i,
	input wire logic	column_strobe_n_i,
	input wire logic	write_strobe_n_i,
	input wire logic [6:0]	muxed_address_bus_i,
	output logic [6:0]	row_o,
	output logic [6:0]	col_o,
	output logic [3:0]	bank_o,
	output logic	wr_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0]	ras_q_ff;
	logic	cas_q_ff;
	always_ff @(posedge clk_i) begin
		ras_q_ff <= row_strobe_n_i;
		cas_q_ff <= column_strobe_n_i;
		if (ras_q_ff == 4'hF && row_strobe_n_i != 4'hF) begin
			row_o <= muxed_address_bus_i;
			bank_o <= ~row_strobe_n_i;
		end
		if (cas_q_ff && !column_strobe_n_i) begin
			col_o <= muxed_address_bus_i;
			wr_o <= !write_strobe_n_i;
		end
	end
endmodule

// File: testbench/dram_refresh_access_controller_test.sv
// Directed bench for the RAM controller with array model.
// Assumes the port checker is bound in.
module dram_refresh_access_controller_test
	import dram_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned RI = 100;
	logic clk_i, arst_n_i, row_msb_or_ram_size_strap_i, ram_size_strap_i, bank_select_lsb_i;
	logic bank_msb_or_advanced_read_strap_i, advanced_read_strap_i, read_request_n_i, store_request_n_i;
	logic guarded_select_n_i, refresh_request_i, crystal_or_clock_strap_i, column_strobe_n_o;
	logic write_strobe_n_o, transfer_done_n_o, access_begin_n_o, external_clock_sel_o, m_wr, late, seen;
	logic [5:0] row_address_in_i;
	logic [6:0] column_address_in_i, muxed_address_bus_o, m_row, m_col, r0;
	logic [3:0] row_strobe_n_o, m_bank;
	int fails = 0, checks_done = 0, cyc = 0, n;
	dram_refresh_access_controller #(.REFRESH_INTERVAL(RI)) dram_refresh_access_controller_inst (.*);
	dram_array_model dram_array_model_inst (.clk_i(clk_i), .row_strobe_n_i(row_strobe_n_o),
		.column_strobe_n_i(column_strobe_n_o), .write_strobe_n_i(write_strobe_n_o),
		.muxed_address_bus_i(muxed_address_bus_o), .row_o(m_row), .col_o(m_col), .bank_o(m_bank), .wr_o(m_wr));
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails = fails + 1;
			test_done;
		end
	end
	task automatic test_done;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cmp(string nm, logic [6:0] e, logic [6:0] s);
		checks_done++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic tk(int k);
		repeat (k) @(negedge clk_i);
	endtask
	task automatic cnt_cas(int k, output int c);
		c = 0;
		repeat (k) begin
			if (column_strobe_n_o === 1'b0)
				c++;
			tk(1);
		end
	endtask
	task automatic wait_ref;
		for (int i = 0; i < RI + 20 && row_strobe_n_o !== 4'h0; i++)
			tk(1);
		seen = (row_strobe_n_o === 4'h0);
	endtask
	task automatic access(logic wr, logic [1:0] bk, logic [6:0] row, logic [6:0] col, logic [6:0] er, logic lt);
		int i;
		{bank_msb_or_advanced_read_strap_i, bank_select_lsb_i} = bk;
		{row_msb_or_ram_size_strap_i, row_address_in_i} = row;
		column_address_in_i = col;
		guarded_select_n_i = 1'b0;
		store_request_n_i = !wr;
		read_request_n_i = wr;
		for (i = 0; i < 40 && column_strobe_n_o !== 1'b0; i++)
			tk(1);
		{guarded_select_n_i, store_request_n_i, read_request_n_i} = 3'h7;
		for (i = 0; i < 40 && transfer_done_n_o !== 1'b0; i++) begin
			late = access_begin_n_o;
			tk(1);
		end
		cmp("row", er, m_row);
		cmp("col", col, m_col);
		cmp("bank", 7'(4'h1 << bk), 7'(m_bank));
		cmp("write", 7'(wr), 7'(m_wr));
		cmp("late", 7'(lt), 7'(late));
		tk(4);
	endtask
	initial begin
		{arst_n_i, row_msb_or_ram_size_strap_i, ram_size_strap_i, bank_select_lsb_i} = 4'h0;
		{bank_msb_or_advanced_read_strap_i, advanced_read_strap_i, crystal_or_clock_strap_i} = 3'h0;
		{read_request_n_i, store_request_n_i, guarded_select_n_i, refresh_request_i} = 4'hE;
		row_address_in_i = 6'h00;
		column_address_in_i = 7'h00;
		tk(2);
		cmp("idle mux", MUX_IDLE, muxed_address_bus_o);
		cmp("idle ctl", 7'h1E, {2'h0, column_strobe_n_o, write_strobe_n_o, transfer_done_n_o, access_begin_n_o, external_clock_sel_o});
		arst_n_i = 1'b1;
		$display("test reset done");
		for (int b = 0; b < 4; b++)
			access(b[0], b[1:0], 7'h55 ^ 7'(b), 7'h2A ^ 7'(b << 2), 7'h55 ^ 7'(b), 1'b0);
		$display("test banks done");
		ram_size_strap_i = 1'b1;
		access(1'b1, 2'h3, 7'h0A, 7'h45, 7'h4A, 1'b0);
		ram_size_strap_i = 1'b0;
		$display("test small ram done");
		refresh_request_i = 1'b1;
		tk(1);
		refresh_request_i = 1'b0;
		wait_ref;
		r0 = muxed_address_bus_o;
		cmp("pin refresh", 7'h01, 7'(seen));
		tk(8);
		wait_ref;
		cmp("timer row", r0 + 7'h01, muxed_address_bus_o);
		access(1'b0, 2'h1, 7'h33, 7'h4C, 7'h33, 1'b1);
		access(1'b1, 2'h2, 7'h0F, 7'h70, 7'h0F, 1'b0);
		$display("test refresh done");
		{bank_msb_or_advanced_read_strap_i, bank_select_lsb_i} = 2'h1;
		{guarded_select_n_i, read_request_n_i, refresh_request_i} = 3'h1;
		tk(1);
		refresh_request_i = 1'b0;
		tk(3);
		cmp("access first", 7'h0D, 7'(row_strobe_n_o));
		tk(3);
		{guarded_select_n_i, read_request_n_i} = 2'h3;
		wait_ref;
		cmp("refresh after", 7'h01, 7'(seen));
		$display("test arbitration done");
		tk(12);
		{advanced_read_strap_i, bank_msb_or_advanced_read_strap_i, bank_select_lsb_i} = 3'h6;
		{guarded_select_n_i, read_request_n_i, refresh_request_i} = 3'h3;
		tk(1);
		refresh_request_i = 1'b0;
		cnt_cas(20, n);
		cmp("status read", 7'h01, 7'(n != 0));
		cmp("adv bank", 7'h04, 7'(m_bank));
		{read_request_n_i, refresh_request_i} = 2'h1;
		tk(1);
		refresh_request_i = 1'b0;
		cnt_cas(20, n);
		cmp("status low", 7'h00, 7'(n));
		{advanced_read_strap_i, bank_msb_or_advanced_read_strap_i, read_request_n_i, guarded_select_n_i} = 4'h3;
		$display("test advanced done");
		tk(4);
		read_request_n_i = 1'b0;
		cnt_cas(30, n);
		cmp("guarded", 7'h00, 7'(n));
		read_request_n_i = 1'b1;
		crystal_or_clock_strap_i = 1'b1;
		tk(2);
		cmp("ext clock", 7'h01, 7'(external_clock_sel_o));
		crystal_or_clock_strap_i = 1'b0;
		tk(2);
		cmp("xtal clock", 7'h00, 7'(external_clock_sel_o));
		$display("test straps done");
		test_done;
	end
endmodule
